// ---- core/stack_vector_seq.sv ----
// Interrupt context push/restore sequencer with stack pointer and vector
`timescale 1ns/1ps
// Behaviour
// - Push and restore take five memory cycles
// - One advance pulse per cycle steps counter
// - Level and direction select the parameter
// - Stack pointer loads field and address
// - Pointer increments on push, decrements restoring
// - Fifteen-bit pointer readable on I/O bus
// - Granted break drives pointer as address, except in push-jump
// - Vector holds field bits and address bits
// - Vector readable; level code fills bits 7-10
// - Field enable at level 1, time state 1
// - Vector onto data bus in second push cycle
// - Load strobe moves vector into program counter
// - Two maintenance commands simulate levels, start push
// - Simulated level lasts one processor cycle
// - Restore reverses order, decrementing five times
// - Interrupt push only when trial level beats present
// - Present level loads at enable level 5
// - Push-jump skips priority, jumps to target
module stack_vector_seq
	import stack_seq_pkg::*;
(
	input  wire logic                      CLK,
	input  wire logic                      RESET_N,
	input  wire logic                      TIME_STATE_1,
	input  wire logic [14:0]               EXT_LEVELS,
	input  wire logic                      INT_ENABLE,
	input  wire stack_seq_pkg::stack_addr_t ACC,
	input  wire logic                      LOAD_STACK,
	input  wire logic                      LOAD_VECTOR,
	input  wire logic                      READ_STACK,
	input  wire logic                      READ_VECTOR,
	input  wire logic                      RESTORE_REQ,
	input  wire logic [3:0]                RESTORE_LEVEL,
	input  wire logic                      PUSH_JUMP_REQ,
	input  wire logic [2:0]                PUSH_JUMP_FIELD,
	input  wire stack_seq_pkg::data_word_t PUSH_JUMP_WORD,
	input  wire logic                      SIM_LEVEL_STROBE,
	input  wire logic [14:0]               SIM_LEVELS,
	input  wire logic                      MAINT_PUSH,
	input  wire logic                      BREAK_GRANT_IRQ,
	input  wire logic                      BREAK_DONE,
	output logic                           BREAK_REQ,
	output logic                           PUSH_ACTIVE,
	output logic                           RESTORE_ACTIVE,
	output logic [3:0]                     ENABLE_LEVEL,
	output stack_seq_pkg::param_sel_t      PARAM_SEL,
	output logic                           SEQ_ADVANCE_PULSE,
	output logic                           STACK_PTR_INC,
	output logic                           STACK_PTR_DEC,
	output logic                           STACK_ADDR_DRIVE_EN,
	output stack_seq_pkg::stack_addr_t     DATA_ADDR,
	output logic                           VECTOR_TO_PC_DRIVE,
	output logic                           JUMP_TO_PC_DRIVE,
	output stack_seq_pkg::data_word_t      DATA_BUS,
	output logic                           PC_LOAD_STROBE,
	output logic                           FIELD_ENABLE,
	output logic [2:0]                     FIELD_BITS,
	output stack_seq_pkg::stack_addr_t     IO_BUS,
	output logic                           IO_BUS_VALID,
	output logic [3:0]                     PRESENT_LEVEL,
	output logic                           PRESENT_LEVEL_LOAD
);
	import stack_seq_pkg::*;

	typedef struct packed {
		logic        push;
		logic        restore;
		logic        pj;
		logic        maint;
		logic [3:0]  seq;
		logic        adv;
		stack_addr_t sp;
		vector_t     vec;
		logic [3:0]  pres;
		logic [3:0]  code;
		logic [14:0] sim;
		logic [6:0]  sim_cnt;
		logic [2:0]  pj_field;
		data_word_t  pj_word;
		logic        break_req;
		param_sel_t  param_sel;
		logic        adv_pulse;
		logic        sp_inc;
		logic        sp_dec;
		logic        addr_drive;
		stack_addr_t addr;
		logic        vec_drive;
		logic        jump_drive;
		data_word_t  data;
		logic        pc_load;
		logic        field_en;
		logic [2:0]  field;
		stack_addr_t io;
		logic        io_valid;
		logic        pres_load;
	} state_t;

	state_t s_q;
	state_t s_d;
	prio_if prio ();

	level_encoder #(.N(NUM_LEVELS)) u_enc (.p(prio.enc));

	assign prio.levels  = EXT_LEVELS | s_q.sim;
	assign prio.present = s_q.pres;

	logic busy;
	assign busy = s_q.push || s_q.restore;

	// Parameter slot order: push walks 0..4, restore walks 4..0
	function automatic param_sel_t slot(input logic push, input logic [3:0] lvl);
		logic [3:0] idx;
		idx = (lvl > LVL_SKIPPED) ? lvl - 4'h1 : lvl;
		if (push)
			slot = 3'(idx);
		else
			slot = 3'(LVL_LAST - lvl);
	endfunction : slot

	always_comb begin
		s_d            = s_q;
		s_d.adv_pulse  = 1'b0;
		s_d.sp_inc     = 1'b0;
		s_d.sp_dec     = 1'b0;
		s_d.pc_load    = s_q.vec_drive || s_q.jump_drive;
		s_d.vec_drive  = 1'b0;
		s_d.jump_drive = 1'b0;
		s_d.field_en   = 1'b0;
		s_d.pres_load  = 1'b0;
		s_d.io_valid   = 1'b0;
		s_d.io         = '0;

		// Software commands
		if (LOAD_STACK)
			s_d.sp = ACC;
		if (LOAD_VECTOR)
			s_d.vec = ACC[0:VEC_W-1];
		if (READ_STACK) begin
			s_d.io       = s_q.sp;
			s_d.io_valid = 1'b1;
		end else if (READ_VECTOR) begin
			s_d.io       = {s_q.vec[0:6], s_q.code, 4'h0};
			s_d.io_valid = 1'b1;
		end

		// Maintenance levels are held for one processor cycle only
		if (s_q.sim_cnt != 7'h00) begin
			s_d.sim_cnt = s_q.sim_cnt - 7'h01;
			if (s_q.sim_cnt == 7'h01)
				s_d.sim = '0;
		end
		if (SIM_LEVEL_STROBE) begin
			s_d.sim     = SIM_LEVELS;
			s_d.sim_cnt = SIM_HOLD_CYCLES;
		end

		if (!busy) begin
			if (PUSH_JUMP_REQ) begin
				s_d.push     = 1'b1;
				s_d.pj       = 1'b1;
				s_d.seq      = LVL_PUSH_FIRST;
				s_d.pj_field = PUSH_JUMP_FIELD;
				s_d.pj_word  = PUSH_JUMP_WORD;
			end else if (RESTORE_REQ) begin
				s_d.restore = 1'b1;
				s_d.seq     = LVL_REST_FIRST;
				s_d.sp      = s_q.sp - 15'h0001;
				s_d.sp_dec  = 1'b1;
			end else if ((prio.priority_win && INT_ENABLE) || MAINT_PUSH) begin
				s_d.push  = 1'b1;
				s_d.maint = MAINT_PUSH;
				s_d.seq   = LVL_PUSH_FIRST;
				s_d.code  = prio.code;
			end
		end else begin
			// A grant without push-jump puts the stack pointer on the address lines
			s_d.addr_drive = BREAK_GRANT_IRQ && !s_q.pj;
			if (BREAK_GRANT_IRQ)
				s_d.addr = s_q.sp;
			if (BREAK_DONE)
				s_d.adv = 1'b1;
			if (s_q.push && s_q.seq == LVL_VECTOR && TIME_STATE_1) begin
				s_d.field_en = 1'b1;
				s_d.field    = s_q.pj ? s_q.pj_field : s_q.vec[0:2];
			end
			if (s_q.adv) begin
				s_d.adv       = 1'b0;
				s_d.adv_pulse = 1'b1;
				if (s_q.push && s_q.seq == LVL_VECTOR) begin
					s_d.vec_drive  = !s_q.pj;
					s_d.jump_drive = s_q.pj;
					s_d.data       = s_q.pj ? s_q.pj_word
					                        : {3'h0, s_q.vec[3:6], s_q.code, 1'b0};
				end
				// Push skips level 2: the counter steps twice after level 1
				if (s_q.push && s_q.seq == LVL_VECTOR)
					s_d.seq = s_q.seq + 4'h2;
				else
					s_d.seq = s_q.seq + 4'h1;
				if (s_q.push) begin
					s_d.sp     = s_q.sp + 15'h0001;
					s_d.sp_inc = 1'b1;
				end else if (s_q.seq != LVL_LAST) begin
					// Pre-decrement at start makes five decrements in all
					s_d.sp     = s_q.sp - 15'h0001;
					s_d.sp_dec = 1'b1;
				end
				if (s_q.seq == LVL_LAST) begin
					s_d.pres_load = 1'b1;
					s_d.pres      = s_q.push ? s_q.code : RESTORE_LEVEL;
					s_d.push      = 1'b0;
					s_d.restore   = 1'b0;
					s_d.pj        = 1'b0;
					s_d.maint     = 1'b0;
					s_d.seq       = LVL_PUSH_FIRST;
				end
			end
		end
		s_d.break_req = s_d.push || s_d.restore;
		s_d.param_sel = slot(s_d.push, s_d.seq);
	end

	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			s_q      <= '0;
			s_q.sp   <= SP_RESET;
			s_q.vec  <= VEC_RESET;
			s_q.pres <= PRES_RESET;
			s_q.code <= PRES_RESET;
		end else begin
			s_q <= s_d;
		end
	end

	assign BREAK_REQ           = s_q.break_req;
	assign PUSH_ACTIVE         = s_q.push;
	assign RESTORE_ACTIVE      = s_q.restore;
	assign ENABLE_LEVEL        = s_q.seq;
	assign PARAM_SEL           = s_q.param_sel;
	assign SEQ_ADVANCE_PULSE   = s_q.adv_pulse;
	assign STACK_PTR_INC       = s_q.sp_inc;
	assign STACK_PTR_DEC       = s_q.sp_dec;
	assign STACK_ADDR_DRIVE_EN = s_q.addr_drive;
	assign DATA_ADDR           = s_q.addr;
	assign VECTOR_TO_PC_DRIVE  = s_q.vec_drive;
	assign JUMP_TO_PC_DRIVE    = s_q.jump_drive;
	assign DATA_BUS            = s_q.data;
	assign PC_LOAD_STROBE      = s_q.pc_load;
	assign FIELD_ENABLE        = s_q.field_en;
	assign FIELD_BITS          = s_q.field;
	assign IO_BUS              = s_q.io;
	assign IO_BUS_VALID        = s_q.io_valid;
	assign PRESENT_LEVEL       = s_q.pres;
	assign PRESENT_LEVEL_LOAD  = s_q.pres_load;

	// Helper: advance pulses counted within one operation
	logic [3:0] adv_cnt;
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N)
			adv_cnt <= 4'h0;
		else if (!busy)
			adv_cnt <= 4'h0;
		else if (s_q.adv)
			adv_cnt <= adv_cnt + 4'h1;
	end

	// Helper: cycles since the last maintenance strobe, saturating so it never wraps
	logic [7:0] sim_age;
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N)
			sim_age <= 8'hff;
		else if (SIM_LEVEL_STROBE)
			sim_age <= 8'h00;
		else if (sim_age != 8'hff)
			sim_age <= sim_age + 8'h01;
	end

	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RESET_N);

	chk_five_cycles: assert property (
		$fell(busy) |-> adv_cnt == 4'(NUM_CYCLES)) else $error("operation not five cycles");
	chk_adv_single: assert property (
		SEQ_ADVANCE_PULSE |=> !SEQ_ADVANCE_PULSE) else $error("advance pulse too long");
	chk_push_increment: assert property (
		s_q.push && s_q.adv |=> s_q.sp == $past(s_q.sp) + 15'h0001 && STACK_PTR_INC)
		else $error("push did not increment pointer");
	chk_restore_decrement: assert property (
		s_q.restore && s_q.adv && s_q.seq != LVL_LAST |=> s_q.sp == $past(s_q.sp) - 15'h0001)
		else $error("restore did not decrement pointer");
	chk_stack_address: assert property (
		busy && BREAK_GRANT_IRQ && !s_q.pj |=> STACK_ADDR_DRIVE_EN && DATA_ADDR == $past(s_q.sp))
		else $error("stack address not driven on grant");
	chk_field_enable: assert property (
		s_q.push && s_q.seq == LVL_VECTOR && TIME_STATE_1 |=> FIELD_ENABLE)
		else $error("field enable missing");
	chk_vector_pc_load: assert property (
		VECTOR_TO_PC_DRIVE |-> DATA_BUS[7:10] == s_q.code ##1 PC_LOAD_STROBE)
		else $error("vector not followed by pc load");
	chk_level_load: assert property (
		PRESENT_LEVEL != $past(PRESENT_LEVEL) |-> $past(s_q.seq == LVL_LAST && s_q.adv))
		else $error("present level changed outside level 5");
	chk_sim_hold: assert property (
		sim_age >= {1'b0, SIM_HOLD_CYCLES} |-> s_q.sim == 15'h0000)
		else $error("simulated level held too long");
	chk_priority_gate: assert property (
		!busy && !PUSH_JUMP_REQ && !MAINT_PUSH && !(prio.priority_win && INT_ENABLE)
		|=> !s_q.push)
		else $error("push started without priority");
	chk_return_idle: assert property (
		s_q.seq == LVL_LAST && s_q.adv |=> !busy && ENABLE_LEVEL == LVL_PUSH_FIRST)
		else $error("sequencer not idle after fifth cycle");

	cov_push_done: cover property ($fell(s_q.push) && !$past(s_q.pj));
	cov_restore_done: cover property ($fell(s_q.restore));
	cov_push_jump: cover property (JUMP_TO_PC_DRIVE ##1 PC_LOAD_STROBE);
	cov_sim_push: cover property (SIM_LEVEL_STROBE ##[1:80] $rose(s_q.push));
endmodule : stack_vector_seq

// ---- core/stack_seq_pkg.sv ----
// Shared constants and types for the interrupt stack and vector sequencer
package stack_seq_pkg;
	localparam int          STACK_W         = 15;
	localparam int          VEC_W           = 10;
	localparam int          LEVEL_W         = 4;
	localparam int          NUM_LEVELS      = 15;
	localparam int          DATA_W          = 12;
	localparam int          FIELD_W         = 3;
	localparam int          SEQ_W           = 4;
	localparam int          NUM_CYCLES      = 5;
	localparam logic [3:0]  LVL_SKIPPED     = 4'h2;
	localparam logic [3:0]  LVL_VECTOR      = 4'h1;
	localparam logic [3:0]  LVL_LAST        = 4'h5;
	localparam logic [3:0]  LVL_PUSH_FIRST  = 4'h0;
	localparam logic [3:0]  LVL_REST_FIRST  = 4'h1;
	localparam logic [3:0]  PRES_RESET      = 4'hf;
	localparam logic [14:0] SP_RESET        = 15'h0000;
	localparam logic [9:0]  VEC_RESET       = 10'h000;
	localparam int          CLK_PERIOD_NS   = 20;
	localparam int          PROC_CYCLE_NS   = 1600;
	localparam int          SIM_HOLD_INT    = PROC_CYCLE_NS / CLK_PERIOD_NS;
	localparam logic [6:0]  SIM_HOLD_CYCLES = 7'(SIM_HOLD_INT);
	typedef logic [0:STACK_W-1] stack_addr_t;
	typedef logic [0:VEC_W-1]   vector_t;
	typedef logic [0:DATA_W-1]  data_word_t;
	typedef logic [2:0]         param_sel_t;
endpackage : stack_seq_pkg

// ---- core/prio_if.sv ----
// Carrier between the sequencer and its priority encoder
`timescale 1ns/1ps
interface prio_if;
	logic [14:0] levels;
	logic [3:0]  present;
	logic [3:0]  code;
	logic        valid;
	logic        priority_win;
	modport enc (input levels, input present, output code, output valid, output priority_win);
	modport ctl (output levels, output present, input code, input valid, input priority_win);
endinterface : prio_if

// ---- core/level_encoder.sv ----
// Priority encoder of the request levels and comparison with the present level
`timescale 1ns/1ps
module level_encoder #(
	parameter int N = 15
) (
	prio_if.enc p
);
	import stack_seq_pkg::*;

	if (N < 1 || N > 15) begin : g_bad_n
		$error("level_encoder: N must be 1 to 15");
	end

	// Line 0 is highest priority; its code is 0, so a lower code wins
	always_comb begin
		p.code  = PRES_RESET;
		p.valid = 1'b0;
		for (int i = N - 1; i >= 0; i--) begin
			if (p.levels[i]) begin
				p.code  = 4'(i);
				p.valid = 1'b1;
			end
		end
		p.priority_win = p.valid && (p.code < p.present);
	end
endmodule : level_encoder

// ---- testbench/cpu_break_model.sv ----
// Processor and break multiplexer stand-in facing the sequencer
`timescale 1ns/1ps
module cpu_break_model (
	input  wire logic       CLK,
	input  wire logic       RESET_N,
	input  wire logic       BREAK_REQ,
	input  wire logic [3:0] STALL,
	output logic            GRANT,
	output logic            DONE,
	output logic            TS1
);
	logic [3:0] wait_q;
	logic [2:0] done_q;
	logic [1:0] ts_q;
	// Five breaks at most per request; a sixth would hide a missing end of sequence
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			{GRANT, DONE, TS1, wait_q, done_q, ts_q} <= '0;
		end else begin
			ts_q <= ts_q + 2'h1;
			TS1 <= (ts_q == 2'h0);
			DONE <= 1'b0;
			if (!BREAK_REQ) begin
				{GRANT, wait_q, done_q} <= '0;
			end else if (wait_q < STALL) begin
				wait_q <= wait_q + 4'h1;
			end else if (!GRANT && done_q < 3'h5) begin
				GRANT <= 1'b1;
			end else if (GRANT) begin
				DONE <= 1'b1;
				GRANT <= 1'b0;
				wait_q <= 4'h0;
				done_q <= done_q + 3'h1;
			end
		end
	end
endmodule : cpu_break_model

// ---- testbench/test_interrupt_stack_vector_sequencer.sv ----
// Self-checking bench for the stack and vector sequencer
`timescale 1ns/1ps
module test_interrupt_stack_vector_sequencer;
	import stack_seq_pkg::*;
	localparam int C_LDS = 0, C_LDV = 1, C_RDS = 2, C_RDV = 3, C_RES = 4, C_PJ = 5, C_SIM = 6, C_MP = 7;
	localparam stack_addr_t SP0 = 15'h1230;
	localparam stack_addr_t VEC_A = {3'h5, 7'h66, 5'h00};
	logic CLK, RESET_N, TIME_STATE_1, INT_ENABLE, BREAK_GRANT_IRQ, BREAK_DONE;
	logic BREAK_REQ, PUSH_ACTIVE, RESTORE_ACTIVE, SEQ_ADVANCE_PULSE, STACK_PTR_INC;
	logic STACK_PTR_DEC, STACK_ADDR_DRIVE_EN, VECTOR_TO_PC_DRIVE, JUMP_TO_PC_DRIVE;
	logic PC_LOAD_STROBE, FIELD_ENABLE, IO_BUS_VALID, PRESENT_LEVEL_LOAD;
	logic [14:0] EXT_LEVELS, SIM_LEVELS;
	logic [3:0] RESTORE_LEVEL, ENABLE_LEVEL, PRESENT_LEVEL, stall;
	logic [2:0] PUSH_JUMP_FIELD, FIELD_BITS, fld;
	logic [7:0] cmd;
	param_sel_t PARAM_SEL;
	stack_addr_t ACC, DATA_ADDR, IO_BUS, first_addr;
	data_word_t PUSH_JUMP_WORD, DATA_BUS, vbus, jbus;
	int n_errors, check_count, cycles, n_adv, n_inc, n_dec, n_drv, n_vec, n_jmp, n_pcl, n_pll;
	logic [14:0] psel;
	stack_vector_seq u_dut (.LOAD_STACK(cmd[0]), .LOAD_VECTOR(cmd[1]), .READ_STACK(cmd[2]),
		.READ_VECTOR(cmd[3]), .RESTORE_REQ(cmd[4]), .PUSH_JUMP_REQ(cmd[5]),
		.SIM_LEVEL_STROBE(cmd[6]), .MAINT_PUSH(cmd[7]), .*);
	cpu_break_model u_cpu (.CLK(CLK), .RESET_N(RESET_N), .BREAK_REQ(BREAK_REQ), .STALL(stall),
		.GRANT(BREAK_GRANT_IRQ), .DONE(BREAK_DONE), .TS1(TIME_STATE_1));
	always #10 CLK = ~CLK;
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR %s expected %0h seen %0h", what, exp, seen);
		end
	endtask : chk
	task automatic close_out();
		$display("checks %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : close_out
	task automatic pulse(input int b);
		@(posedge CLK);
		cmd[b] <= 1'b1;
		@(posedge CLK);
		cmd <= '0;
	endtask : pulse
	task automatic load(input int b, input stack_addr_t v);
		@(posedge CLK);
		ACC <= v;
		pulse(b);
	endtask : load
	task automatic rd(input int b, input string what, input logic [31:0] exp);
		pulse(b);
		@(negedge CLK);
		chk("io_valid", IO_BUS_VALID, 1);
		chk(what, IO_BUS, exp);
	endtask : rd
	// Counts everything the sequencer shows from request up to its return to idle
	task automatic watch();
		int k;
		{n_adv, n_inc, n_dec, n_drv, n_vec, n_jmp, n_pcl, n_pll} = '0;
		fld = 3'h0;
		k = 0;
		while (BREAK_REQ !== 1'b1 && k < 20) begin
			@(negedge CLK);
			k++;
		end
		// First busy cycle and the cycle after the fall are both counted
		k = 0;
		psel = '0;
		while (k < 400) begin
			if (BREAK_REQ === 1'b1 && (k == 0 || SEQ_ADVANCE_PULSE === 1'b1))
				psel = {psel[11:0], PARAM_SEL};
			n_adv += SEQ_ADVANCE_PULSE;
			n_pll += PRESENT_LEVEL_LOAD;
			n_inc += STACK_PTR_INC;
			n_dec += STACK_PTR_DEC;
			n_pcl += PC_LOAD_STROBE;
			if (STACK_ADDR_DRIVE_EN === 1'b1) begin
				if (n_drv == 0) first_addr = DATA_ADDR;
				n_drv++;
			end
			if (VECTOR_TO_PC_DRIVE === 1'b1) begin
				n_vec++;
				vbus = DATA_BUS;
			end
			if (JUMP_TO_PC_DRIVE === 1'b1) begin
				n_jmp++;
				jbus = DATA_BUS;
			end
			if (FIELD_ENABLE === 1'b1) fld = FIELD_BITS;
			if (BREAK_REQ !== 1'b1) break;
			@(negedge CLK);
			k++;
		end
		chk("adv", n_adv, 5);
		chk("level_load", n_pll, 1);
		chk("idle", {PUSH_ACTIVE, RESTORE_ACTIVE, ENABLE_LEVEL}, 0);
	endtask : watch
	task automatic restore(input logic [3:0] lvl, input stack_addr_t sp_end);
		@(posedge CLK);
		RESTORE_LEVEL <= lvl;
		stall <= 4'h0;
		pulse(C_RES);
		watch();
		chk("dec", n_dec, 5);
		chk("inc", n_inc, 0);
		chk("addr", first_addr, sp_end + 15'h4);
		chk("drives", n_vec + n_jmp, 0);
		chk("param_sel", psel, {3'h4, 3'h3, 3'h2, 3'h1, 3'h0});
		chk("present", PRESENT_LEVEL, lvl);
		rd(C_RDS, "sp", sp_end);
		@(posedge CLK);
		stall <= 4'h3;
		$display("restore done");
	endtask : restore
	task automatic t_push();
		vector_t v;
		v = VEC_A[0:9];
		load(C_LDS, SP0);
		load(C_LDV, VEC_A);
		rd(C_RDS, "sp", SP0);
		rd(C_RDV, "vector", {v[0:6], 4'hf, 4'h0});
		@(posedge CLK);
		EXT_LEVELS <= 15'h0008;
		INT_ENABLE <= 1'b1;
		watch();
		chk("inc", n_inc, 5);
		chk("param_sel", psel, {3'h0, 3'h1, 3'h2, 3'h3, 3'h4});
		chk("addr", first_addr, SP0);
		chk("vec_n", n_vec, 1);
		chk("vec_bus", vbus, {3'h0, v[3:6], 4'h3, 1'b0});
		chk("pcl", n_pcl, 1);
		chk("field", fld, v[0:2]);
		chk("present", PRESENT_LEVEL, 4'h3);
		@(posedge CLK);
		EXT_LEVELS <= 15'h0028;
		repeat (40) @(posedge CLK);
		EXT_LEVELS <= '0;
		rd(C_RDS, "sp", SP0 + 15'h5);
		$display("push done");
	endtask : t_push
	task automatic t_pjump();
		@(posedge CLK);
		INT_ENABLE <= 1'b0;
		PUSH_JUMP_FIELD <= 3'h6;
		PUSH_JUMP_WORD <= 12'ha5c;
		pulse(C_PJ);
		watch();
		chk("inc", n_inc, 5);
		chk("pj_param_sel", psel, {3'h0, 3'h1, 3'h2, 3'h3, 3'h4});
		chk("jmp_n", n_jmp + n_vec, 1);
		chk("jmp_bus", jbus, 12'ha5c);
		chk("drive", n_drv, 0);
		chk("field", fld, 3'h6);
		restore(4'hf, SP0);
		$display("push jump done");
	endtask : t_pjump
	task automatic t_maint();
		@(posedge CLK);
		INT_ENABLE <= 1'b1;
		SIM_LEVELS <= 15'h0004;
		pulse(C_SIM);
		watch();
		chk("inc", n_inc, 5);
		chk("present", PRESENT_LEVEL, 4'h2);
		repeat (60) @(posedge CLK);
		restore(4'hf, SP0);
		INT_ENABLE <= 1'b0;
		pulse(C_SIM);
		repeat (100) @(posedge CLK);
		INT_ENABLE <= 1'b1;
		repeat (20) @(negedge CLK);
		chk("expired", {BREAK_REQ, PRESENT_LEVEL}, 5'h0f);
		pulse(C_MP);
		watch();
		chk("inc", n_inc, 5);
		$display("maintenance done");
	endtask : t_maint
	always @(posedge CLK) begin
		cycles++;
		if (cycles == 5000) begin
			n_errors++;
			close_out();
		end
	end
	initial begin
		{CLK, RESET_N, INT_ENABLE, cmd, ACC, EXT_LEVELS, SIM_LEVELS} = '0;
		{PUSH_JUMP_FIELD, PUSH_JUMP_WORD} = '0;
		RESTORE_LEVEL = 4'hf;
		stall = 4'h3;
		repeat (12) @(posedge CLK);
		RESET_N <= 1'b1;
		@(negedge CLK);
		chk("present", PRESENT_LEVEL, 4'hf);
		chk("busy", {BREAK_REQ, ENABLE_LEVEL}, 0);
		t_push();
		restore(4'hf, SP0);
		t_pjump();
		t_maint();
		close_out();
	end
endmodule : test_interrupt_stack_vector_sequencer
